// *** hdl/sdrcb_col_gen.sv ***
// Burst column generator: column of a burst step, sequential or interleaved.
// Assumes the step count starts at zero at the first column of the burst.
`timescale 1ns/100ps
`default_nettype none
`include "sdrcb_defs.svh"

module sdrcb_col_gen
	import sdrcb_pkg::*;
(
	input wire logic [`SDRCB_COL_W-1:0] start,
	input wire logic [`SDRCB_COL_W-1:0] step,
	input wire logic [2:0] bl,
	input wire logic bt,
	output logic [`SDRCB_COL_W-1:0] col
);
	logic [`SDRCB_CNT_W-1:0] len;
	logic [`SDRCB_COL_W-1:0] wrap;
	logic [`SDRCB_COL_W-1:0] moved;

	assign len = sdrcb_burst_len(bl);
	// Full page gives a zero low byte, so the wrap mask becomes all ones
	assign wrap = len[`SDRCB_COL_W-1:0] - 8'h01;
	assign moved = bt ? (start ^ step) : (start + step);
	assign col = (start & ~wrap) | (moved & wrap);

endmodule

`default_nettype wire

// *** hdl/sdrcb_core.sv ***
// Synchronous DRAM core: command decode, bursts, clock suspend, low power.
// Assumes a controller that drives all inputs synchronous to clk.
//
// Function
// [R01] All inputs captured on rising clock edge
// [R02] Enabled edge steps burst and output data
// [R03] Clock enable low freezes outputs and burst
// [R04] Low power only entered with banks idle
// [R05] Clock enable wakes device from low power
// [R06] Other inputs ignored while in low power
// [R07] Controller activates row before read or write
// [R08] Bursts 1,2,4,8,page with burst stop
// [R09] Auto precharge closes row after burst
// [R10] Four banks, 2048 rows, 256 columns
// [R11] Mode sets latency 2/3 and order
// [R12] Auto refresh and self refresh supported
// [R13] Four masks, one per byte lane
// [R14] Chip select high ignores command
// [R15] Row strobe commands: activate or precharge
// [R16] Row from address, column, auto-precharge bit
// [R17] Mask high blocks that write byte
`timescale 1ns/100ps
`default_nettype none
`include "sdrcb_defs.svh"

module sdrcb_core
	import sdrcb_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [`SDRCB_BA_W-1:0] ba,
	input wire logic [`SDRCB_ROW_W-1:0] addr,
	input wire logic [`SDRCB_LANES-1:0] dqm,
	input wire logic [`SDRCB_DQ_W-1:0] dq_in,
	output logic [`SDRCB_DQ_W-1:0] dq_out,
	output logic [`SDRCB_LANES-1:0] dq_oe,
	output logic [`SDRCB_BANKS-1:0] bank_active,
	output logic power_down,
	output logic self_refresh
);
	import sdrcb_pkg::*;

	sdrcb_regs_s st_reg;
	sdrcb_regs_s st_next;
	logic [2:0] cmd;
	logic [`SDRCB_COL_W-1:0] col;
	logic [`SDRCB_IDX_W-1:0] acc_idx;
	logic [`SDRCB_DQ_W-1:0] old_word;
	logic [`SDRCB_DQ_W-1:0] wr_word;
	logic [`SDRCB_LANES-1:0] wr_mask;
	logic [`SDRCB_LANES-1:0] rd_oe;
	logic wr_en;
	logic run_en;
	logic rd_go;
	logic wr_go;
	logic [`SDRCB_DQ_W-1:0] mem [0:(1 << `SDRCB_IDX_W)-1]; // [R10]

	assign cmd = {ras_n, cas_n, we_n};
	assign run_en = (st_reg.state == SDRCB_RUN) && st_reg.ckeq;
	assign rd_go = run_en && !cs_n && cmd == `SDRCB_CMD_RD && st_reg.open[ba] && cke;
	assign wr_go = run_en && !cs_n && cmd == `SDRCB_CMD_WR && st_reg.open[ba];

	sdrcb_col_gen u_col (
		.start(st_reg.start),
		.step(st_reg.cnt),
		.bl(st_reg.bl),
		.bt(st_reg.bt),
		.col(col)
	);

	assign old_word = mem[acc_idx];

	// Byte lanes merge new data only where the mask is low
	genvar g;
	generate
		for (g = 0; g < `SDRCB_LANES; g++) begin : g_lane
			assign wr_word[g*`SDRCB_LANE_W +: `SDRCB_LANE_W] = wr_mask[g] ?
				old_word[g*`SDRCB_LANE_W +: `SDRCB_LANE_W] :
				dq_in[g*`SDRCB_LANE_W +: `SDRCB_LANE_W]; // [R13] [R17]
		end
	endgenerate

	always_comb begin
		st_next = st_reg;
		st_next.ckeq = cke; // [R01]
		wr_en = 1'b0;
		wr_mask = dqm;
		rd_oe = '0;
		acc_idx = {st_reg.bank, st_reg.rows[st_reg.bank], col};
		case (st_reg.state)
			SDRCB_PD: begin
				if (cke) begin
					st_next.state = SDRCB_RUN; // [R05] [R06]
				end
			end
			SDRCB_SR: begin
				st_next.ref_row = st_reg.ref_row + 11'h001; // [R12]
				if (cke) begin
					st_next.state = SDRCB_RUN; // [R05] [R06]
				end
			end
			SDRCB_RUN: begin
				if (st_reg.ckeq) begin // [R03]
					if (st_reg.burst) begin
						st_next.cnt = st_reg.cnt + 8'h01; // [R02]
						if (st_reg.wr) begin
							wr_en = 1'b1;
						end else begin
							rd_oe = ~dqm; // [R13]
						end
						if (!st_reg.page && ({1'b0, st_reg.cnt} + 9'h001) == st_reg.len) begin
							st_next.burst = 1'b0; // [R08]
							if (st_reg.ap) begin
								st_next.open[st_reg.bank] = 1'b0; // [R09]
							end
						end
					end
					if (!cs_n) begin // [R14]
						case (cmd)
							`SDRCB_CMD_ACT: begin
								st_next.open[ba] = 1'b1; // [R15]
								st_next.rows[ba] = addr; // [R16]
							end
							`SDRCB_CMD_PRE: begin
								if (addr[`SDRCB_AP_BIT]) begin
									st_next.open = '0;
								end else begin
									st_next.open[ba] = 1'b0; // [R15]
								end
								if (addr[`SDRCB_AP_BIT] || ba == st_reg.bank) begin
									st_next.burst = 1'b0;
								end
							end
							`SDRCB_CMD_RD, `SDRCB_CMD_WR: begin
								if (st_reg.open[ba]) begin // [R07]
									st_next.bank = ba;
									st_next.start = addr[`SDRCB_COL_W-1:0]; // [R16]
									st_next.ap = addr[`SDRCB_AP_BIT]; // [R16]
									st_next.wr = (cmd == `SDRCB_CMD_WR);
									st_next.len = sdrcb_burst_len(st_reg.bl); // [R08]
									st_next.page = (st_reg.bl == `SDRCB_BL_PAGE);
									st_next.cnt = '0;
									st_next.burst = 1'b1;
									if (cmd == `SDRCB_CMD_WR) begin
										wr_en = 1'b1;
										acc_idx = {ba, st_reg.rows[ba], addr[`SDRCB_COL_W-1:0]};
										rd_oe = '0;
										st_next.cnt = 8'h01;
										if (st_reg.bl == `SDRCB_BL_1) begin
											st_next.burst = 1'b0;
											if (addr[`SDRCB_AP_BIT]) begin
												st_next.open[ba] = 1'b0; // [R09]
											end
										end
									end
								end
							end
							`SDRCB_CMD_BST: begin
								st_next.burst = 1'b0; // [R08]
							end
							`SDRCB_CMD_MRS: begin
								if (st_reg.open == '0 && !st_reg.burst) begin
									st_next.bl = addr[`SDRCB_MR_BL_LSB +: 3]; // [R11]
									st_next.bt = addr[`SDRCB_MR_BT_BIT];
									st_next.cl = addr[`SDRCB_MR_CL_LSB +: 3];
								end
							end
							`SDRCB_CMD_REF: begin
								if (st_reg.open == '0) begin
									st_next.ref_row = st_reg.ref_row + 11'h001; // [R12]
									if (!cke) begin
										st_next.state = SDRCB_SR;
									end
								end
							end
							default: begin
							end
						endcase
					end
					// Read pipeline sets the latency from read to data
					if (st_reg.cl == `SDRCB_CL_3) begin // [R11]
						st_next.dq_out = st_reg.pipe;
						st_next.oe = st_reg.pipe_oe;
						st_next.pipe = old_word;
						st_next.pipe_oe = rd_oe;
					end else begin
						st_next.dq_out = old_word; // [R02]
						st_next.oe = rd_oe;
						st_next.pipe_oe = '0;
					end
					if (!cke && st_next.open == '0 && !st_next.burst && st_next.state == SDRCB_RUN) begin
						st_next.state = SDRCB_PD; // [R04]
						st_next.oe = '0;
						st_next.pipe_oe = '0;
					end
				end
			end
			default: begin
				st_next.state = SDRCB_RUN;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg <= SDRCB_RST;
		end else begin
			st_reg <= st_next; // [R01]
		end
	end

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[acc_idx] <= wr_word; // [R13]
		end
	end

	assign dq_out = st_reg.dq_out;
	assign dq_oe = st_reg.oe;
	assign bank_active = st_reg.open;
	assign power_down = st_reg.state[`SDRCB_PD_BIT];
	assign self_refresh = st_reg.state[`SDRCB_SR_BIT];

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_rd_cl2;
		rd_go && st_reg.cl == `SDRCB_CL_2;
	endsequence

	sequence s_rd_cl3;
		rd_go && st_reg.cl == `SDRCB_CL_3;
	endsequence

	sequence s_step_clear;
		st_reg.ckeq && cs_n && dqm == 4'h0;
	endsequence

	a_read_cl2: assert property (s_rd_cl2 ##1 s_step_clear |=> dq_oe == 4'hF) // [R11]
		else $error("read data missing two clocks after read");
	a_read_cl3: assert property (s_rd_cl3 ##1 s_step_clear ##1 st_reg.ckeq |=> dq_oe == 4'hF) // [R02]
		else $error("read data missing three clocks after read");
	a_clock_freeze: assert property ((st_reg.state == SDRCB_RUN) && !st_reg.ckeq
		|=> $stable(dq_out) && $stable(bank_active) && $stable(st_reg.cnt)) // [R03]
		else $error("state moved while clock suspended");
	a_cs_ignore: assert property (run_en && cs_n && !st_reg.burst
		|=> $stable(bank_active) && $stable(st_reg.rows)) // [R14]
		else $error("command taken with chip select high");
	a_act_open: assert property (run_en && !cs_n && cmd == `SDRCB_CMD_ACT
		|=> bank_active[$past(ba)] && st_reg.rows[$past(ba)] == $past(addr)) // [R15]
		else $error("activate did not open row");
	a_pd_entry: assert property (run_en && !cke && cs_n && st_reg.open == '0 && !st_reg.burst
		|=> power_down) // [R04]
		else $error("power down not entered");
	a_lp_exit: assert property ((power_down || self_refresh) && cke
		|=> !power_down && !self_refresh) // [R05]
		else $error("low power not left on clock enable");
	a_lp_deaf: assert property (power_down && !cke
		|=> power_down && $stable(bank_active) && $stable({st_reg.bl, st_reg.cl})) // [R06]
		else $error("inputs observed in power down");
	a_wr_autopre: assert property (wr_go && st_reg.bl == `SDRCB_BL_1 && addr[`SDRCB_AP_BIT]
		|=> !st_reg.burst && !bank_active[$past(ba)]) // [R09]
		else $error("auto precharge did not close row");
	a_burst_stop: assert property (run_en && !cs_n && cmd == `SDRCB_CMD_BST |=> !st_reg.burst) // [R08]
		else $error("burst stop ignored");
	a_self_ref: assert property (run_en && !cs_n && cmd == `SDRCB_CMD_REF && !cke
		&& st_reg.open == '0 |=> self_refresh) // [R12]
		else $error("self refresh not entered");
	a_byte_mask: assert property (wr_en && wr_mask == 4'hF |-> wr_word == old_word) // [R17]
		else $error("masked lanes written");

endmodule

`default_nettype wire

// *** hdl/sdrcb_defs.svh ***
// Constants of the synchronous DRAM core: widths, mode fields, commands.
// Assumes inclusion by the package and the core; guarded against repeats.
`ifndef SDRCB_DEFS_SVH
`define SDRCB_DEFS_SVH

`define SDRCB_DQ_W 32
`define SDRCB_LANES 4
`define SDRCB_LANE_W 8
`define SDRCB_BANKS 4
`define SDRCB_BA_W 2
`define SDRCB_ROW_W 11
`define SDRCB_COL_W 8
`define SDRCB_CNT_W 9
`define SDRCB_IDX_W 21
`define SDRCB_AP_BIT 10

`define SDRCB_MR_BL_LSB 0
`define SDRCB_MR_BT_BIT 3
`define SDRCB_MR_CL_LSB 4

`define SDRCB_BL_1 3'h0
`define SDRCB_BL_2 3'h1
`define SDRCB_BL_4 3'h2
`define SDRCB_BL_8 3'h3
`define SDRCB_BL_PAGE 3'h7
`define SDRCB_CL_2 3'h2
`define SDRCB_CL_3 3'h3

`define SDRCB_CMD_MRS 3'h0
`define SDRCB_CMD_REF 3'h1
`define SDRCB_CMD_PRE 3'h2
`define SDRCB_CMD_ACT 3'h3
`define SDRCB_CMD_WR 3'h4
`define SDRCB_CMD_RD 3'h5
`define SDRCB_CMD_BST 3'h6

`define SDRCB_PD_BIT 1
`define SDRCB_SR_BIT 2

`endif

// *** hdl/sdrcb_pkg.sv ***
// Types and burst-length decode of the synchronous DRAM core.
// Assumes the constants header is on the include path.
`include "sdrcb_defs.svh"

package sdrcb_pkg;

	typedef enum logic [2:0] {
		SDRCB_RUN = 3'b001,
		SDRCB_PD = 3'b010,
		SDRCB_SR = 3'b100
	} sdrcb_state_e;

	typedef struct packed {
		sdrcb_state_e state;
		logic ckeq;
		logic [2:0] bl;
		logic bt;
		logic [2:0] cl;
		logic [`SDRCB_BANKS-1:0] open;
		logic [`SDRCB_BANKS-1:0][`SDRCB_ROW_W-1:0] rows;
		logic burst;
		logic wr;
		logic ap;
		logic page;
		logic [`SDRCB_BA_W-1:0] bank;
		logic [`SDRCB_COL_W-1:0] start;
		logic [`SDRCB_COL_W-1:0] cnt;
		logic [`SDRCB_CNT_W-1:0] len;
		logic [`SDRCB_ROW_W-1:0] ref_row;
		logic [`SDRCB_DQ_W-1:0] dq_out;
		logic [`SDRCB_LANES-1:0] oe;
		logic [`SDRCB_DQ_W-1:0] pipe;
		logic [`SDRCB_LANES-1:0] pipe_oe;
	} sdrcb_regs_s;

	localparam sdrcb_regs_s SDRCB_RST = '{state: SDRCB_RUN, cl: `SDRCB_CL_2, default: '0};

	// Words in one burst for a burst-length code
	function automatic logic [`SDRCB_CNT_W-1:0] sdrcb_burst_len(input logic [2:0] bl);
		case (bl)
			`SDRCB_BL_2: return 9'h002;
			`SDRCB_BL_4: return 9'h004;
			`SDRCB_BL_8: return 9'h008;
			`SDRCB_BL_PAGE: return 9'h100;
			default: return 9'h001;
		endcase
	endfunction

endpackage

// *** tb/sdrcb_ctrl_model.sv ***
// Memory controller model: drives commands, masks, write data, clock enable.
// Assumes the bench calls its tasks; every input changes 1 ns after clk rises.
`timescale 1ns/100ps
`default_nettype none
module sdrcb_ctrl_model (
	input wire logic clk,
	output logic cke,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [1:0] ba,
	output logic [10:0] addr,
	output logic [3:0] dqm,
	output logic [31:0] dq_in
);
	initial begin
		cke = 1'b1;
		cs_n = 1'b1;
		{ras_n, cas_n, we_n} = 3'h3;
		ba = 2'h0;
		addr = 11'h000;
		dqm = 4'h0;
		dq_in = 32'h0;
	end
	// One command, launched after an edge and held until the next
	task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [10:0] a,
		input logic [31:0] d);
		@(posedge clk);
		#1;
		cs_n = 1'b0;
		{ras_n, cas_n, we_n} = c;
		ba = b;
		addr = a;
		dqm = 4'h0;
		dq_in = d;
	endtask
	// Clock enable change in the same step as the command just launched
	task automatic cke_set(input logic k);
		cke = k;
	endtask
	// Deselected cycle carrying an activate code, so it must be ignored
	task automatic nop(input logic [3:0] m, input logic [31:0] d, input logic k);
		@(posedge clk);
		#1;
		cs_n = 1'b1;
		{ras_n, cas_n, we_n} = 3'h3;
		dqm = m;
		dq_in = d;
		cke = k;
	endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench of the DRAM core with a controller model in front.
// Assumes the design package and constants header are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "sdrcb_defs.svh"
module tb;
	import sdrcb_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cke, cs_n, ras_n, cas_n, we_n;
	logic [1:0] ba;
	logic [10:0] addr;
	logic [3:0] dqm, dq_oe, bank_active;
	logic [31:0] dq_in, dq_out;
	logic power_down, self_refresh;
	logic [31:0] exp_mem [0:255];
	int err_total = 0;
	int cmp_count = 0;
	always #12.5 clk = ~clk;
	sdrcb_ctrl_model ctl (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
		.we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in));
	sdrcb_core dut (.clk(clk), .rst(rst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in),
		.dq_out(dq_out), .dq_oe(dq_oe), .bank_active(bank_active),
		.power_down(power_down), .self_refresh(self_refresh));
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) ctl.nop(4'h0, ~dq_in, 1'b1);
	endtask
	// Sequential four-word write; mask m1 applies to the second word only
	task automatic wr_burst(input logic [7:0] col, input logic ap, input logic [31:0] base,
		input logic [3:0] m1);
		logic [31:0] d;
		logic [7:0] c;
		for (int k = 0; k < 4; k++) begin
			d = base + k;
			c = {col[7:2], col[1:0] + k[1:0]};
			if (k == 0) ctl.cmd(`SDRCB_CMD_WR, 2'h1, {ap, 2'h0, col}, d);
			else ctl.nop((k == 1) ? m1 : 4'h0, d, 1'b1);
			for (int l = 0; l < 4; l++)
				if (!(k == 1 && m1[l])) exp_mem[c][8*l +: 8] = d[8*l +: 8];
		end
	endtask
	// Four-word read; sus drops clock enable for one cycle mid-burst
	task automatic rd_burst(input logic [7:0] col, input logic ilv, input int lat,
		input logic sus);
		logic c1, c2, k;
		logic [7:0] c;
		int j, w;
		c1 = 1'b1;
		c2 = 1'b1;
		j = -1;
		w = -lat;
		ctl.cmd(`SDRCB_CMD_RD, 2'h1, {3'h0, col}, ~dq_in);
		for (int i = 0; i < 20 && w < 4; i++) begin
			k = !(sus && i == lat + 1);
			ctl.nop(4'h0, ~dq_in, k);
			if (c2) j++;
			c2 = c1;
			c1 = k;
			w = j - (lat - 1);
			c = ilv ? (col ^ w[7:0]) : {col[7:2], col[1:0] + w[1:0]};
			if (w >= 0) check({28'h0, dq_oe}, (w < 4) ? 32'hF : 32'h0, "read enable");
			if (w >= 0 && w < 4) check(dq_out, exp_mem[c], "read word");
		end
		if (w < 4) check(32'h0, 32'h1, "read burst timeout");
	endtask
	task automatic t_access;
		ctl.cmd(`SDRCB_CMD_MRS, 2'h0, 11'h022, ~dq_in);
		ctl.cmd(`SDRCB_CMD_ACT, 2'h1, 11'h555, ~dq_in);
		idle(1);
		check({28'h0, bank_active}, 32'h2, "bank open");
		wr_burst(8'h04, 1'b0, 32'h1111_0000, 4'h0);
		wr_burst(8'h06, 1'b1, 32'h2222_0000, 4'h5);
		idle(4);
		check({28'h0, bank_active}, 32'h0, "auto precharge");
		ctl.cmd(`SDRCB_CMD_ACT, 2'h1, 11'h555, ~dq_in);
		rd_burst(8'h05, 1'b0, 2, 1'b0);
		$display("test access done");
	endtask
	task automatic t_ilv;
		ctl.cmd(`SDRCB_CMD_PRE, 2'h0, 11'h400, ~dq_in);
		idle(1);
		ctl.cmd(`SDRCB_CMD_MRS, 2'h0, 11'h03A, ~dq_in);
		ctl.cmd(`SDRCB_CMD_ACT, 2'h1, 11'h555, ~dq_in);
		rd_burst(8'h05, 1'b1, 3, 1'b1);
		$display("test interleave done");
	endtask
	task automatic t_lowpower;
		ctl.nop(4'h0, ~dq_in, 1'b0);
		ctl.nop(4'h0, ~dq_in, 1'b1);
		check({31'h0, power_down}, 32'h0, "no power down with open bank");
		ctl.cmd(`SDRCB_CMD_PRE, 2'h0, 11'h400, ~dq_in);
		ctl.nop(4'h0, ~dq_in, 1'b0);
		ctl.nop(4'h0, ~dq_in, 1'b0);
		check({31'h0, power_down}, 32'h1, "power down entry");
		ctl.cmd(`SDRCB_CMD_ACT, 2'h2, 11'h001, ~dq_in);
		ctl.nop(4'h0, ~dq_in, 1'b0);
		check({27'h0, power_down, bank_active}, 32'h10, "input ignored");
		ctl.nop(4'h0, ~dq_in, 1'b1);
		ctl.nop(4'h0, ~dq_in, 1'b1);
		check({31'h0, power_down}, 32'h0, "power down exit");
		idle(1);
		ctl.cmd(`SDRCB_CMD_REF, 2'h0, 11'h000, ~dq_in);
		ctl.cke_set(1'b0);
		ctl.nop(4'h0, ~dq_in, 1'b0);
		check({31'h0, self_refresh}, 32'h1, "self refresh entry");
		ctl.nop(4'h0, ~dq_in, 1'b1);
		ctl.nop(4'h0, ~dq_in, 1'b1);
		check({31'h0, self_refresh}, 32'h0, "self refresh exit");
		$display("test low power done");
	endtask
	// Single write with auto precharge, then a page burst cut by burst stop
	task automatic t_modes;
		ctl.cmd(`SDRCB_CMD_MRS, 2'h0, 11'h020, ~dq_in);
		ctl.cmd(`SDRCB_CMD_ACT, 2'h1, 11'h555, ~dq_in);
		ctl.cmd(`SDRCB_CMD_WR, 2'h1, 11'h410, 32'h3333_0010);
		exp_mem[8'h10] = 32'h3333_0010;
		idle(1);
		check({28'h0, bank_active}, 32'h0, "single write auto precharge");
		ctl.cmd(`SDRCB_CMD_MRS, 2'h0, 11'h027, ~dq_in);
		ctl.cmd(`SDRCB_CMD_ACT, 2'h1, 11'h555, ~dq_in);
		ctl.cmd(`SDRCB_CMD_WR, 2'h1, 11'h00F, 32'h4444_000F);
		ctl.nop(4'hF, 32'h4444_0010, 1'b1);
		ctl.nop(4'h0, 32'h4444_0011, 1'b1);
		ctl.cmd(`SDRCB_CMD_BST, 2'h1, 11'h000, ~dq_in);
		exp_mem[8'h0F] = 32'h4444_000F;
		exp_mem[8'h11] = 32'h4444_0011;
		ctl.cmd(`SDRCB_CMD_RD, 2'h1, 11'h00F, ~dq_in);
		idle(2);
		check(dq_out, exp_mem[8'h0F], "page word 0");
		ctl.cmd(`SDRCB_CMD_BST, 2'h1, 11'h000, ~dq_in);
		check(dq_out, exp_mem[8'h10], "masked word kept");
		idle(1);
		check(dq_out, exp_mem[8'h11], "page word 2");
		idle(1);
		check({28'h0, dq_oe}, 32'h0, "burst stop");
		$display("test modes done");
	endtask
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		#1;
		rst = 1'b0;
		t_access();
		t_ilv();
		t_lowpower();
		t_modes();
		end_sim();
	end
endmodule
`default_nettype wire
